/* test/dtdd_far_model.sv */
// Tone source and steering network model beside the decoder
`timescale 1ns/1ns
`default_nettype none
module dtdd_far_model #(
    parameter int GUARD_CYC = 200
) (
    // Clock
    input  wire logic        mclk,
    // Tone half periods in cycles, zero for silence
    input  wire logic [15:0] lowHalf,
    input  wire logic [15:0] highHalf,
    // Decoder side
    input  wire logic        earlyValid,
    input  wire logic        guardDriveOut,
    input  wire logic        guardDriveOeN,
    output logic             lowToneIn,
    output logic             highToneIn,
    output logic             steerGuardNodeIn
);
    logic [15:0] lowCnt;
    logic [15:0] highCnt;
    int          charge;
    initial begin
        lowCnt = 16'h0000;
        highCnt = 16'h0000;
        lowToneIn = 1'b0;
        highToneIn = 1'b0;
        charge = 0;
    end
    // Square waves standing in for the limited filter outputs
    always @(posedge mclk) begin
        lowCnt <= (lowCnt + 16'h0001 >= lowHalf) ? 16'h0000 : lowCnt + 16'h0001;
        highCnt <= (highCnt + 16'h0001 >= highHalf) ? 16'h0000 : highCnt + 16'h0001;
        if (lowHalf != 16'h0000 && lowCnt + 16'h0001 >= lowHalf) lowToneIn <= ~lowToneIn;
        if (highHalf != 16'h0000 && highCnt + 16'h0001 >= highHalf) highToneIn <= ~highToneIn;
    end
    // Guard drive sets the node full or empty; undriven, it charges while early valid is high and decays otherwise
    always @(posedge mclk) begin
        if (!guardDriveOeN) charge <= guardDriveOut ? 2 * GUARD_CYC : 0;
        else if (earlyValid && charge < 2 * GUARD_CYC) charge <= charge + 1;
        else if (!earlyValid && charge > 0) charge <= charge - 1;
    end
    assign steerGuardNodeIn = (charge >= GUARD_CYC);
endmodule : dtdd_far_model
`default_nettype wire

/* test/dual_tone_digit_decoder_tb.sv */
// Self-checking bench for the tone digit decoder
`timescale 1ns/1ns
`default_nettype none
`include "dtdd_consts.svh"
module dual_tone_digit_decoder_tb;
    logic        mclk = 1'b0;
    logic        reset_n, hsel, hwrite, hreadyout, hresp, lowToneIn, highToneIn;
    logic        letterInhibit, standbyRequest, codeBusEnable, steerGuardNodeIn;
    logic        guardDriveOut, guardDriveOeN, earlyValid, delayedValidFlag;
    logic        digitCodeOeN, irq, rdPend, dvPrev, inhPhase;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  digitCodeOut;
    logic [15:0] lowHalf, highHalf;
    logic [31:0] rdQ[$];
    logic [3:0]  codeQ[$];
    int          mismatches = 0;
    int          checksDone = 0;
    int          cycles = 0;
    int          i;
    always #50 mclk = ~mclk;
    dtdd_decoder DUT (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lowToneIn(lowToneIn),
        .highToneIn(highToneIn), .letterInhibit(letterInhibit),
        .standbyRequest(standbyRequest), .codeBusEnable(codeBusEnable),
        .steerGuardNodeIn(steerGuardNodeIn), .guardDriveOut(guardDriveOut),
        .guardDriveOeN(guardDriveOeN), .earlyValid(earlyValid),
        .delayedValidFlag(delayedValidFlag), .digitCodeOut(digitCodeOut),
        .digitCodeOeN(digitCodeOeN), .irq(irq));
    dtdd_far_model #(.GUARD_CYC(200)) farEnd (.mclk(mclk), .lowHalf(lowHalf),
        .highHalf(highHalf), .earlyValid(earlyValid), .guardDriveOut(guardDriveOut),
        .guardDriveOeN(guardDriveOeN), .lowToneIn(lowToneIn), .highToneIn(highToneIn),
        .steerGuardNodeIn(steerGuardNodeIn));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic testDone();
        if (mismatches == 0 && checksDone > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : testDone
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       input logic [31:0] ex);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, ofs};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        if (!wr) rdQ.push_back(ex);
        rdPend <= !wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rdPend <= 1'b0;
    endtask : bus
    // Read data and latched codes checked as they appear
    always @(posedge mclk) begin
        dvPrev <= delayedValidFlag;
        if (rdPend) chk("hresp hreadyout", 32'h1, {30'h0, hresp, hreadyout});
        if (rdPend && hreadyout === 1'b1) chk("hrdata", rdQ.pop_front(), hrdata);
        if (delayedValidFlag === 1'b1 && dvPrev === 1'b0) begin
            chk("digitCodeOut", {28'h0, codeQ.pop_front()}, {28'h0, digitCodeOut});
            chk("ev guard", 32'h6, {29'h0, earlyValid, guardDriveOut, guardDriveOeN});
        end
        if (inhPhase) chk("earlyValid", 32'h0, {31'h0, earlyValid});
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            mismatches++;
            $display("BAD timeout expected %h seen %h", 0, cycles);
            testDone();
        end
    end
    initial begin
        {reset_n, hsel, hwrite, rdPend, dvPrev, inhPhase} = 6'h00;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {letterInhibit, standbyRequest, codeBusEnable, lowHalf, highHalf} = 35'h0;
        i = $urandom(87);
        repeat (3) @(posedge mclk);
        chk("reset outs", 32'h60, {23'h0, earlyValid, delayedValidFlag, guardDriveOeN,
            digitCodeOeN, irq, digitCodeOut});
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        bus(1'b0, `DTDD_OFS_CTRL, 32'h0, 32'h0);
        bus(1'b1, 8'h20, $urandom(), 32'h0);
        bus(1'b0, 8'h20, 32'h0, 32'h0);
        bus(1'b0, `DTDD_OFS_INT_MASK, 32'h0, 32'h0);
        bus(1'b1, `DTDD_OFS_INT_MASK, 32'h7, 32'h0);
        bus(1'b0, `DTDD_OFS_INT_MASK, 32'h0, 32'h7);
        codeBusEnable <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("digitCodeOeN", 32'h0, {31'h0, digitCodeOeN});
        // Digit 0: 941 Hz row with 1336 Hz column
        codeQ.push_back(4'ha);
        lowHalf <= 16'd5313;
        highHalf <= 16'd3743;
        for (i = 0; i < 60000 && delayedValidFlag !== 1'b1; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b0, `DTDD_OFS_CODE, 32'h0, 32'haa);
        // Letter D with inhibit set
        letterInhibit <= 1'b1;
        highHalf <= 16'd3062;
        for (i = 0; i < 20000 && delayedValidFlag !== 1'b0; i++) @(posedge mclk);
        chk("delayedValidFlag", 32'h0, {31'h0, delayedValidFlag});
        inhPhase <= 1'b1;
        repeat (32000) @(posedge mclk);
        inhPhase <= 1'b0;
        chk("held code", 32'ha, {28'h0, digitCodeOut});
        bus(1'b0, `DTDD_OFS_INT_STAT, 32'h0, 32'h7);
        standbyRequest <= 1'b1;
        letterInhibit <= 1'b0;
        repeat (20) @(posedge mclk);
        chk("standby ev", 32'h0, {31'h0, earlyValid});
        lowHalf <= 16'h0000;
        highHalf <= 16'h0000;
        bus(1'b1, `DTDD_OFS_INT_MASK, 32'h0, 32'h0);
        repeat (3) @(posedge mclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `DTDD_OFS_INT_STAT, 32'h7, 32'h0);
        bus(1'b0, `DTDD_OFS_INT_STAT, 32'h0, 32'h0);
        bus(1'b1, `DTDD_OFS_CTRL, 32'h3, 32'h0);
        bus(1'b0, `DTDD_OFS_CTRL, 32'h0, 32'h3);
        testDone();
    end
endmodule : dual_tone_digit_decoder_tb
`default_nettype wire

/* verilog/dtdd_consts.svh */
// Register map, field positions, reset values and timing counts
`ifndef DTDD_CONSTS_SVH
`define DTDD_CONSTS_SVH

// Register byte offsets
`define DTDD_OFS_CTRL       8'h00
`define DTDD_OFS_STATUS     8'h04
`define DTDD_OFS_CODE       8'h08
`define DTDD_OFS_INT_STAT   8'h0c
`define DTDD_OFS_INT_MASK   8'h10

// Control fields
`define DTDD_CTRL_STANDBY   0
`define DTDD_CTRL_INHIBIT   1
`define DTDD_CTRL_RST       2'h0

// Interrupt fields
`define DTDD_INT_REG        0
`define DTDD_INT_PAUSE      1
`define DTDD_INT_SUPPR      2
`define DTDD_INT_RST        3'h0

// Pin synchroniser lanes
`define DTDD_PIN_LOW        0
`define DTDD_PIN_HIGH       1
`define DTDD_PIN_INH        2
`define DTDD_PIN_STBY       3
`define DTDD_PIN_OE         4
`define DTDD_PIN_STEER      5

// Timing
`define DTDD_CLK_HZ         32'd10000000
`define DTDD_CLK_PERIOD_NS  32'd100
`define DTDD_SETTLE_NS      32'd2000
`define DTDD_SETTLE_CYC     ((`DTDD_SETTLE_NS + `DTDD_CLK_PERIOD_NS - 32'd1) / `DTDD_CLK_PERIOD_NS)

// Tone groups in Hz, acceptance window, match count and timeout
`define DTDD_TONE_L0_HZ     32'd697
`define DTDD_TONE_L1_HZ     32'd770
`define DTDD_TONE_L2_HZ     32'd852
`define DTDD_TONE_L3_HZ     32'd941
`define DTDD_TONE_H0_HZ     32'd1209
`define DTDD_TONE_H1_HZ     32'd1336
`define DTDD_TONE_H2_HZ     32'd1477
`define DTDD_TONE_H3_HZ     32'd1633
`define DTDD_TONE_TOL_DIV   32'd50
`define DTDD_TONE_MATCH     2'h3
`define DTDD_TONE_TIMEOUT   15'h4000

`endif

/* verilog/dtdd_decoder.sv */
// Dual tone digit decoder: validation, steering, code latch and registers
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "dtdd_consts.svh"
module dtdd_decoder (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic      [31:0]  hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Limited tone inputs
    input  wire logic         lowToneIn,
    input  wire logic         highToneIn,
    // Mode pins
    input  wire logic         letterInhibit,
    input  wire logic         standbyRequest,
    input  wire logic         codeBusEnable,
    // Steering node
    input  wire logic         steerGuardNodeIn,
    output logic              guardDriveOut,
    output logic              guardDriveOeN,
    // Digit outputs
    output logic              earlyValid,
    output logic              delayedValidFlag,
    output logic      [3:0]   digitCodeOut,
    output logic              digitCodeOeN,
    // Interrupt
    output logic              irq
);
    localparam int         SETTLE_N    = `DTDD_SETTLE_CYC;
    localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_N - 1);

    logic                   rstMeta_reg;
    logic                   rstN_reg;
    logic [5:0]             pinMeta_reg;
    logic [5:0]             pinSync_reg;
    logic [1:0]             ctrl_reg;
    logic [2:0]             intStat_reg;
    logic [2:0]             intMask_reg;
    logic [2:0]             intEvt;
    logic [2:0]             intClr;
    logic                   wrPend_reg;
    logic [7:0]             wrAddr_reg;
    logic                   lowValid;
    logic                   highValid;
    dtdd_pkg::dtdd_idx_t    lowIdx;
    dtdd_pkg::dtdd_idx_t    highIdx;
    logic                   standbyEff;
    logic                   inhibitEff;
    logic                   pairValid;
    logic                   letterBlocked;
    logic                   evNext;
    logic                   supprDly_reg;
    dtdd_pkg::dtdd_code_t   pendingCode_reg;
    dtdd_pkg::dtdd_code_t   code_reg;
    dtdd_pkg::dtdd_steer_t  state_reg;
    dtdd_pkg::dtdd_steer_t  state_next;
    logic [4:0]             settleCnt_reg;
    logic                   steerHigh;
    logic                   registerEvt;
    logic                   pauseEvt;
    logic                   addrPhase;

    // Keypad position to latched code
    function automatic dtdd_pkg::dtdd_code_t digit_code(input logic [1:0] row,
                                                        input logic [1:0] col);
        dtdd_pkg::dtdd_code_t c;
        if (col == 2'h3) begin
            case (row)
                2'h0: c = 4'hd;
                2'h1: c = 4'he;
                2'h2: c = 4'hf;
                default: c = 4'h0;
            endcase
        end else if (row == 2'h3) begin
            case (col)
                2'h0: c = 4'hb;
                2'h1: c = 4'ha;
                default: c = 4'hc;
            endcase
        end else begin
            c = {2'h0, row} + {2'h0, row} + {2'h0, row} + {2'h0, col} + 4'h1;
        end
        return c;
    endfunction : digit_code

    // Reset release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_reg <= 1'b0;
            rstN_reg    <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstN_reg    <= rstMeta_reg;
        end
    end

    // Pin synchronisers
    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            pinMeta_reg <= 6'h0;
            pinSync_reg <= 6'h0;
        end else begin
            pinMeta_reg <= {steerGuardNodeIn, codeBusEnable, standbyRequest,
                            letterInhibit, highToneIn, lowToneIn};
            pinSync_reg <= pinMeta_reg;
        end
    end

    assign standbyEff = pinSync_reg[`DTDD_PIN_STBY] | ctrl_reg[`DTDD_CTRL_STANDBY];
    assign inhibitEff = pinSync_reg[`DTDD_PIN_INH] | ctrl_reg[`DTDD_CTRL_INHIBIT];
    assign steerHigh  = pinSync_reg[`DTDD_PIN_STEER];

    dtdd_tone_meter #(
        .HIGH_GROUP (1'b0)
    ) u_low (
        .mclk      (mclk),
        .rstN      (rstN_reg),
        .hold      (standbyEff),
        .toneIn    (pinSync_reg[`DTDD_PIN_LOW]),
        .toneValid (lowValid),
        .toneIdx   (lowIdx)
    );

    dtdd_tone_meter #(
        .HIGH_GROUP (1'b1)
    ) u_high (
        .mclk      (mclk),
        .rstN      (rstN_reg),
        .hold      (standbyEff),
        .toneIn    (pinSync_reg[`DTDD_PIN_HIGH]),
        .toneValid (highValid),
        .toneIdx   (highIdx)
    );

    assign pairValid     = lowValid & highValid & ~standbyEff;
    assign letterBlocked = inhibitEff & (highIdx == 2'h3);
    assign evNext        = pairValid & ~letterBlocked;

    // Early valid and the code of the pair currently present
    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            earlyValid      <= 1'b0;
            pendingCode_reg <= 4'h0;
            supprDly_reg    <= 1'b0;
        end else begin
            earlyValid   <= evNext;
            supprDly_reg <= pairValid & letterBlocked;
            if (evNext)
                pendingCode_reg <= digit_code(lowIdx, highIdx);
        end
    end

    // Steering sequence
    assign registerEvt = (state_reg == dtdd_pkg::STEER_FREE) & steerHigh & ~standbyEff;
    assign pauseEvt    = (state_reg != dtdd_pkg::STEER_FREE) & ~steerHigh;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dtdd_pkg::STEER_FREE: begin
                if (registerEvt)
                    state_next = dtdd_pkg::STEER_SETTLE;
            end
            dtdd_pkg::STEER_SETTLE: begin
                if (!steerHigh)
                    state_next = dtdd_pkg::STEER_FREE;
                else if (settleCnt_reg == SETTLE_LAST)
                    state_next = dtdd_pkg::STEER_HELD;
            end
            dtdd_pkg::STEER_HELD: begin
                if (!steerHigh)
                    state_next = dtdd_pkg::STEER_FREE;
            end
            default: state_next = dtdd_pkg::STEER_FREE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            state_reg        <= dtdd_pkg::STEER_FREE;
            settleCnt_reg    <= 5'h0;
            delayedValidFlag <= 1'b0;
        end else begin
            state_reg        <= state_next;
            delayedValidFlag <= (state_next == dtdd_pkg::STEER_HELD);
            if (state_reg == dtdd_pkg::STEER_SETTLE)
                settleCnt_reg <= settleCnt_reg + 5'h1;
            else
                settleCnt_reg <= 5'h0;
        end
    end

    // Output latch
    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg)
            code_reg <= 4'h0;
        else if (registerEvt)
            code_reg <= pendingCode_reg;
    end

    // Guard drive: high once registered, low to reset the RC when idle
    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            guardDriveOut <= 1'b0;
            guardDriveOeN <= 1'b1;
        end else if (earlyValid && state_reg != dtdd_pkg::STEER_FREE) begin
            guardDriveOut <= 1'b1;
            guardDriveOeN <= 1'b0;
        end else if (!earlyValid && !steerHigh) begin
            guardDriveOut <= 1'b0;
            guardDriveOeN <= 1'b0;
        end else begin
            guardDriveOut <= 1'b0;
            guardDriveOeN <= 1'b1;
        end
    end

    // Code bus
    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            digitCodeOut <= 4'h0;
            digitCodeOeN <= 1'b1;
        end else begin
            digitCodeOut <= code_reg;
            digitCodeOeN <= ~pinSync_reg[`DTDD_PIN_OE];
        end
    end

    // Interrupt events and clears
    assign intEvt[`DTDD_INT_REG]   = registerEvt;
    assign intEvt[`DTDD_INT_PAUSE] = pauseEvt;
    assign intEvt[`DTDD_INT_SUPPR] = pairValid & letterBlocked & ~supprDly_reg;
    assign intClr = (wrPend_reg && wrAddr_reg == `DTDD_OFS_INT_STAT) ? hwdata[2:0] : 3'h0;

    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            intStat_reg <= `DTDD_INT_RST;
            irq         <= 1'b0;
        end else begin
            intStat_reg <= (intStat_reg & ~intClr) | intEvt;
            irq         <= |(intStat_reg & intMask_reg);
        end
    end

    // AHB-Lite: zero wait, read data staged at the address phase
    assign addrPhase = hsel & htrans[1] & hready;

    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            wrPend_reg <= addrPhase & hwrite;
            wrAddr_reg <= haddr[7:0];
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            ctrl_reg    <= `DTDD_CTRL_RST;
            intMask_reg <= `DTDD_INT_RST;
        end else if (wrPend_reg) begin
            if (wrAddr_reg == `DTDD_OFS_CTRL)
                ctrl_reg <= hwdata[1:0];
            if (wrAddr_reg == `DTDD_OFS_INT_MASK)
                intMask_reg <= hwdata[2:0];
        end
    end

    always_ff @(posedge mclk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            hrdata <= 32'h0;
        end else if (addrPhase && !hwrite && haddr[31:8] == 24'h0) begin
            case (haddr[7:0])
                `DTDD_OFS_CTRL:     hrdata <= {30'h0, ctrl_reg};
                `DTDD_OFS_STATUS:   hrdata <= {21'h0, lowValid, highValid, lowIdx,
                                               highIdx, state_reg, steerHigh,
                                               delayedValidFlag, earlyValid};
                `DTDD_OFS_CODE:     hrdata <= {24'h0, pendingCode_reg, code_reg};
                `DTDD_OFS_INT_STAT: hrdata <= {29'h0, intStat_reg};
                `DTDD_OFS_INT_MASK: hrdata <= {29'h0, intMask_reg};
                default:            hrdata <= 32'h0;
            endcase
        end else begin
            hrdata <= 32'h0;
        end
    end

    property p_ev_drop;
        @(posedge mclk) disable iff (!rstN_reg)
        (!lowValid || !highValid) |=> !earlyValid;
    endproperty
    a_ev_drop: assert property (p_ev_drop) else $error("early valid without pair");

    property p_letter_inh;
        @(posedge mclk) disable iff (!rstN_reg)
        (inhibitEff && highIdx == 2'h3) |=> !earlyValid;
    endproperty
    a_letter_inh: assert property (p_letter_inh) else $error("letter not inhibited");

    property p_latch;
        @(posedge mclk) disable iff (!rstN_reg)
        registerEvt |=> (code_reg == $past(pendingCode_reg)) && !delayedValidFlag;
    endproperty
    a_latch: assert property (p_latch) else $error("latch not updated");

    property p_settle;
        @(posedge mclk) disable iff (!rstN_reg)
        $rose(delayedValidFlag) |-> $past(settleCnt_reg) == SETTLE_LAST && $past(steerHigh);
    endproperty
    a_settle: assert property (p_settle) else $error("delayed valid too early");

    property p_dv_fall;
        @(posedge mclk) disable iff (!rstN_reg)
        !steerHigh |=> !delayedValidFlag;
    endproperty
    a_dv_fall: assert property (p_dv_fall) else $error("delayed valid stuck");

    property p_guard;
        @(posedge mclk) disable iff (!rstN_reg)
        (earlyValid && state_reg != dtdd_pkg::STEER_FREE) |=> guardDriveOut && !guardDriveOeN;
    endproperty
    a_guard: assert property (p_guard) else $error("guard not driving high");

    property p_code_bus;
        @(posedge mclk) disable iff (!rstN_reg)
        pinSync_reg[`DTDD_PIN_OE] |=> !digitCodeOeN && digitCodeOut == $past(code_reg);
    endproperty
    a_code_bus: assert property (p_code_bus) else $error("code bus not driven");

    property p_standby;
        @(posedge mclk) disable iff (!rstN_reg)
        standbyEff |=> !earlyValid ##1 !earlyValid;
    endproperty
    a_standby: assert property (p_standby) else $error("detection active in standby");

    property p_suppr_hold;
        @(posedge mclk) disable iff (!rstN_reg)
        (letterBlocked && !registerEvt) |=> $stable(code_reg) && $stable(pendingCode_reg);
    endproperty
    a_suppr_hold: assert property (p_suppr_hold) else $error("latch changed on letter");

    property p_int_set;
        @(posedge mclk) disable iff (!rstN_reg)
        registerEvt |=> intStat_reg[`DTDD_INT_REG];
    endproperty
    a_int_set: assert property (p_int_set) else $error("registration flag lost");
endmodule : dtdd_decoder
`default_nettype wire

/* verilog/dtdd_pkg.sv */
// Types shared by the tone decoder files
`default_nettype none
package dtdd_pkg;
    typedef enum logic [1:0] {
        STEER_FREE   = 2'h0,
        STEER_SETTLE = 2'h1,
        STEER_HELD   = 2'h3
    } dtdd_steer_t;
    typedef logic [1:0] dtdd_idx_t;
    typedef logic [3:0] dtdd_code_t;
endpackage : dtdd_pkg
`default_nettype wire

/* verilog/dtdd_tone_meter.sv */
// Period counter and classifier for one limited tone group
`timescale 1ns/1ns
`default_nettype none
`include "dtdd_consts.svh"
module dtdd_tone_meter #(
    parameter bit HIGH_GROUP = 1'b0
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rstN,
    // Control
    input  wire logic                hold,
    // Limited tone, already synchronised
    input  wire logic                toneIn,
    // Result
    output logic                     toneValid,
    output var dtdd_pkg::dtdd_idx_t  toneIdx
);
    logic                toneDly_reg;
    logic [14:0]         perCnt_reg;
    logic [1:0]          matchCnt_reg;
    dtdd_pkg::dtdd_idx_t lastIdx_reg;
    logic [2:0]          cls;
    logic                rise;

    function automatic logic [31:0] tone_period(input logic hi, input logic [1:0] idx);
        logic [31:0] hz;
        case ({hi, idx})
            3'h0: hz = `DTDD_TONE_L0_HZ;
            3'h1: hz = `DTDD_TONE_L1_HZ;
            3'h2: hz = `DTDD_TONE_L2_HZ;
            3'h3: hz = `DTDD_TONE_L3_HZ;
            3'h4: hz = `DTDD_TONE_H0_HZ;
            3'h5: hz = `DTDD_TONE_H1_HZ;
            3'h6: hz = `DTDD_TONE_H2_HZ;
            default: hz = `DTDD_TONE_H3_HZ;
        endcase
        return `DTDD_CLK_HZ / hz;
    endfunction : tone_period

    // Hit flag and index of the standard tone whose window holds the period
    function automatic logic [2:0] classify(input logic [14:0] per, input logic hi);
        logic [31:0] nom;
        logic [31:0] p;
        logic [2:0]  res;
        res = 3'h0;
        p = {17'h0, per};
        for (int i = 0; i < 4; i++) begin
            nom = tone_period(hi, 2'(i));
            if (p >= nom - nom / `DTDD_TONE_TOL_DIV && p <= nom + nom / `DTDD_TONE_TOL_DIV)
                res = {1'b1, 2'(i)};
        end
        return res;
    endfunction : classify

    assign rise      = toneIn & ~toneDly_reg;
    assign cls       = classify(perCnt_reg, HIGH_GROUP);
    assign toneValid = (matchCnt_reg == `DTDD_TONE_MATCH);
    assign toneIdx   = lastIdx_reg;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            toneDly_reg <= 1'b0;
        else
            toneDly_reg <= toneIn;
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            perCnt_reg <= 15'h0;
        else if (hold || rise)
            perCnt_reg <= 15'h1;
        else if (perCnt_reg != `DTDD_TONE_TIMEOUT)
            perCnt_reg <= perCnt_reg + 15'h1;
    end

    // Several agreeing periods in a row are needed; one miss drops the tone
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchCnt_reg <= 2'h0;
            lastIdx_reg  <= 2'h0;
        end else if (hold || perCnt_reg == `DTDD_TONE_TIMEOUT) begin
            matchCnt_reg <= 2'h0;
        end else if (rise) begin
            lastIdx_reg <= cls[1:0];
            if (!cls[2])
                matchCnt_reg <= 2'h0;
            else if (cls[1:0] != lastIdx_reg)
                matchCnt_reg <= 2'h1;
            else if (matchCnt_reg != `DTDD_TONE_MATCH)
                matchCnt_reg <= matchCnt_reg + 2'h1;
        end
    end

    property p_t_timeout;
        @(posedge mclk) disable iff (!rstN)
        (perCnt_reg == `DTDD_TONE_TIMEOUT) |=> !toneValid;
    endproperty
    a_t_timeout: assert property (p_t_timeout) else $error("tone kept past timeout");

    property p_t_miss;
        @(posedge mclk) disable iff (!rstN)
        (rise && !cls[2]) |=> !toneValid;
    endproperty
    a_t_miss: assert property (p_t_miss) else $error("off-window period kept tone");
endmodule : dtdd_tone_meter
`default_nettype wire
